// >>> logic/tsc_pkg.sv
// constants for the temperature sensor configuration and low threshold bank
package tsc_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFF_DEVICE_CONFIG = 8'h01;
	localparam logic [7:0]  OFF_LOW_THRESHOLD = 8'h02;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_DEVICE_CONFIG = 16'h60A0;
	localparam logic [15:0] RST_LOW_THRESHOLD = 16'h4B00;
	localparam logic [15:0] RST_HIGH_THRESHOLD = 16'h5000;
	// ----------------------------------------------------------------
	// configuration field positions
	// ----------------------------------------------------------------
	localparam int          BIT_TRIGGER  = 15;
	localparam int          BIT_FAULT_HI = 12;
	localparam int          BIT_FAULT_LO = 11;
	localparam int          BIT_POLARITY = 10;
	localparam int          BIT_INT_MODE = 9;
	localparam int          BIT_SHUTDOWN = 8;
	localparam int          BIT_RATE_HI  = 7;
	localparam int          BIT_RATE_LO  = 6;
	localparam int          BIT_FLAG     = 5;
	localparam int          BIT_WIDE     = 4;
	localparam logic [1:0]  CFG_RSVD_HI  = 2'h3;
	localparam logic [1:0]  RST_FAULT    = 2'h0;
	localparam logic [1:0]  RST_RATE     = 2'h2;
	// threshold masks for the two layouts
	localparam logic [15:0] MASK_NORMAL  = 16'hFFF0;
	localparam logic [15:0] MASK_WIDE    = 16'hFFF8;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam longint      CLK_HZ       = 20000000;
	localparam longint      PERIOD0_MS   = 4000;
	localparam longint      PERIOD1_MS   = 1000;
	localparam longint      PERIOD2_MS   = 250;
	localparam longint      PERIOD3_MS   = 125;
	localparam longint      CYC0 = PERIOD0_MS * CLK_HZ / 1000;
	localparam longint      CYC1 = PERIOD1_MS * CLK_HZ / 1000;
	localparam longint      CYC2 = PERIOD2_MS * CLK_HZ / 1000;
	localparam longint      CYC3 = PERIOD3_MS * CLK_HZ / 1000;
	localparam int          CNT_W = 27;
	// fault counts per field code
	localparam logic [2:0]  FAULTS0 = 3'h1;
	localparam logic [2:0]  FAULTS1 = 3'h2;
	localparam logic [2:0]  FAULTS2 = 3'h4;
	localparam logic [2:0]  FAULTS3 = 3'h6;
	// conversion controller states
	typedef enum logic [1:0] {
		TSC_IDLE = 2'b00,
		TSC_CONV = 2'b01,
		TSC_DONE = 2'b11
	} tsc_state_t;
endpackage : tsc_pkg

// >>> logic/tsc_fault_filter.sv
// consecutive fault filter and comparator or interrupt alert state
module tsc_fault_filter (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        conv_done,
	input  wire logic        above_high,
	input  wire logic        below_low,
	input  wire logic [1:0]  fault_sel,
	input  wire logic        int_mode,
	input  wire logic        ack,
	output logic             comp_active,
	output logic             alert_active
);
	logic [2:0] need;
	logic [2:0] hi_cnt_r;
	logic [2:0] lo_cnt_r;
	logic       comp_r;
	logic       int_r;

	// ----------------------------------------------------------------
	// required consecutive conversions
	// ----------------------------------------------------------------
	always_comb begin
		unique case (fault_sel)
			2'b00: need = tsc_pkg::FAULTS0;
			2'b01: need = tsc_pkg::FAULTS1;
			2'b10: need = tsc_pkg::FAULTS2;
			2'b11: need = tsc_pkg::FAULTS3;
		endcase
	end

	// run counters over successive conversions
	always_ff @(posedge clk) begin
		if (rst) begin
			hi_cnt_r <= 3'h0;
			lo_cnt_r <= 3'h0;
		end else if (conv_done) begin
			hi_cnt_r <= above_high ? ((hi_cnt_r < 3'h6) ? hi_cnt_r + 3'h1 : hi_cnt_r) : 3'h0;
			lo_cnt_r <= below_low ? ((lo_cnt_r < 3'h6) ? lo_cnt_r + 3'h1 : lo_cnt_r) : 3'h0;
		end
	end

	// comparator status: set on high faults, clear on low faults
	always_ff @(posedge clk) begin
		if (rst) begin
			comp_r <= 1'b0;
		end else if (conv_done) begin
			if (above_high && (hi_cnt_r + 3'h1 >= need)) begin
				comp_r <= 1'b1;
			end else if (below_low && (lo_cnt_r + 3'h1 >= need)) begin
				comp_r <= 1'b0;
			end
		end
	end

	// interrupt-style alert: event latched until read back, event wins
	always_ff @(posedge clk) begin
		if (rst) begin
			int_r <= 1'b0;
		end else if (conv_done && ((above_high && !comp_r && (hi_cnt_r + 3'h1 >= need))
				|| (below_low && comp_r && (lo_cnt_r + 3'h1 >= need)))) begin
			int_r <= 1'b1;
		end else if (ack || !int_mode) begin
			int_r <= 1'b0;
		end
	end

	assign comp_active  = comp_r;
	assign alert_active = int_mode ? int_r : comp_r;
endmodule : tsc_fault_filter

// >>> logic/tsc_regs.sv
// configuration and low threshold register bank of the temperature sensor
// How it works
// - trigger write in shutdown starts one conversion
// - trigger reads 0 busy, 1 done
// - fault field sets consecutive conversions needed
// - polarity bit sets alert pin and flag level
// - mode bit picks comparator or interrupt alert
// - shutdown bit stops periodic conversions
// - rate field picks period, reset 250 ms
// - flag is read-only comparator status, polarity applied
// - wide bit selects 12 or 13 bit format
// - comparator status readable in the configuration word, not the interrupt alert
// - low threshold two's complement, 62.5 mC steps
// - low threshold resets to 4B00h
// - unused low threshold bits read zero
module tsc_regs (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic [15:0]      reg_rdata,
	output logic             conv_start,
	input  wire logic        conv_done,
	input  wire logic [15:0] temp_result,
	input  wire logic [15:0] high_threshold,
	output logic [15:0]      low_threshold,
	output logic             wide_format,
	output logic             alert_out
);
	// ----------------------------------------------------------------
	// configuration and threshold storage
	// ----------------------------------------------------------------
	logic [1:0]  fault_r;
	logic        polarity_r;
	logic        int_mode_r;
	logic        shutdown_r;
	logic [1:0]  rate_r;
	logic        wide_r;
	logic [15:0] low_r;
	logic [15:0] rdata_r;
	logic        alert_r;
	logic [15:0] rdata_nxt;

	// ----------------------------------------------------------------
	// conversion control
	// ----------------------------------------------------------------
	logic [tsc_pkg::CNT_W-1:0] tick_r;
	logic [tsc_pkg::CNT_W-1:0] period;
	tsc_pkg::tsc_state_t       state_r;
	logic        wr_cfg;
	logic        wr_low;
	logic        periodic_start;
	logic        single_start;
	logic        trig_read;

	// ----------------------------------------------------------------
	// alert path and compare operands
	// ----------------------------------------------------------------
	logic        comp_active;
	logic        alert_active;
	logic        ack;
	logic [15:0] mask;
	logic signed [15:0] t_s;
	logic signed [15:0] hi_s;
	logic signed [15:0] lo_s;

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	// write strobes per register and the mask of the active layout
	assign wr_cfg = reg_wr && (reg_addr == tsc_pkg::OFF_DEVICE_CONFIG);
	assign wr_low = reg_wr && (reg_addr == tsc_pkg::OFF_LOW_THRESHOLD);
	assign mask   = wide_r ? tsc_pkg::MASK_WIDE : tsc_pkg::MASK_NORMAL;

	// ----------------------------------------------------------------
	// configuration fields
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			fault_r    <= tsc_pkg::RST_FAULT;
			polarity_r <= 1'b0;
			int_mode_r <= 1'b0;
			shutdown_r <= 1'b0;
			rate_r     <= tsc_pkg::RST_RATE;
			wide_r     <= 1'b0;
		end else if (wr_cfg) begin
			fault_r    <= reg_wdata[tsc_pkg::BIT_FAULT_HI:tsc_pkg::BIT_FAULT_LO];
			polarity_r <= reg_wdata[tsc_pkg::BIT_POLARITY];
			int_mode_r <= reg_wdata[tsc_pkg::BIT_INT_MODE];
			shutdown_r <= reg_wdata[tsc_pkg::BIT_SHUTDOWN];
			rate_r     <= reg_wdata[tsc_pkg::BIT_RATE_HI:tsc_pkg::BIT_RATE_LO];
			wide_r     <= reg_wdata[tsc_pkg::BIT_WIDE];
		end
	end

	// ----------------------------------------------------------------
	// low threshold, stored as written, unused bits cleared
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			low_r <= tsc_pkg::RST_LOW_THRESHOLD;
		end else if (wr_low) begin
			low_r <= reg_wdata & mask;
		end
	end

	// ----------------------------------------------------------------
	// conversion period timer, active in continuous mode only
	// ----------------------------------------------------------------
	always_comb begin
		unique case (rate_r)
			2'b00: period = tsc_pkg::CNT_W'(tsc_pkg::CYC0 - 1);
			2'b01: period = tsc_pkg::CNT_W'(tsc_pkg::CYC1 - 1);
			2'b10: period = tsc_pkg::CNT_W'(tsc_pkg::CYC2 - 1);
			2'b11: period = tsc_pkg::CNT_W'(tsc_pkg::CYC3 - 1);
		endcase
	end

	// free-running count, held at zero while shut down
	always_ff @(posedge clk) begin
		if (rst || shutdown_r) begin
			tick_r <= '0;
		end else if (tick_r >= period) begin
			tick_r <= '0;
		end else begin
			tick_r <= tick_r + 1'b1;
		end
	end

	assign periodic_start = !shutdown_r && (tick_r >= period);
	// a trigger only counts while shutdown is already selected
	assign single_start   = wr_cfg && shutdown_r && reg_wdata[tsc_pkg::BIT_TRIGGER]
		&& (state_r != tsc_pkg::TSC_CONV);
	assign conv_start     = periodic_start || single_start;

	// ----------------------------------------------------------------
	// single conversion tracking for the trigger readback
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= tsc_pkg::TSC_IDLE;
		end else begin
			unique case (state_r)
				tsc_pkg::TSC_IDLE: if (single_start) state_r <= tsc_pkg::TSC_CONV;
				tsc_pkg::TSC_CONV: if (conv_done) state_r <= tsc_pkg::TSC_DONE;
				tsc_pkg::TSC_DONE: if (single_start) state_r <= tsc_pkg::TSC_CONV;
				default:           state_r <= tsc_pkg::TSC_IDLE;
			endcase
		end
	end

	// shutdown reads 1 unless a conversion runs; continuous reads 0
	assign trig_read = shutdown_r && (state_r != tsc_pkg::TSC_CONV);

	// ----------------------------------------------------------------
	// threshold compare on finished conversions
	// ----------------------------------------------------------------
	assign t_s  = $signed(temp_result & mask);
	assign hi_s = $signed(high_threshold & mask);
	assign lo_s = $signed(low_r & mask);

	// any finished read acknowledges an interrupt-style alert
	assign ack  = reg_rd;

	// consecutive fault filter and alert mode selection
	tsc_fault_filter u_filter (
		.clk          (clk),
		.rst          (rst),
		.conv_done    (conv_done),
		.above_high   (t_s >= hi_s),
		.below_low    (t_s < lo_s),
		.fault_sel    (fault_r),
		.int_mode     (int_mode_r),
		.ack          (ack),
		.comp_active  (comp_active),
		.alert_active (alert_active)
	);

	// ----------------------------------------------------------------
	// alert pin level follows polarity
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			alert_r <= 1'b1;
		end else begin
			alert_r <= alert_active ~^ polarity_r;
		end
	end

	// ----------------------------------------------------------------
	// read data, registered; unmapped offsets read zero
	// ----------------------------------------------------------------
	always_comb begin
		if (reg_addr == tsc_pkg::OFF_DEVICE_CONFIG) begin
			rdata_nxt = {trig_read, tsc_pkg::CFG_RSVD_HI, fault_r, polarity_r, int_mode_r,
				shutdown_r, rate_r, comp_active ~^ polarity_r, wide_r, 4'h0};
		end else if (reg_addr == tsc_pkg::OFF_LOW_THRESHOLD) begin
			rdata_nxt = low_r & mask;
		end else begin
			rdata_nxt = '0;
		end
	end

	// hold the selected word for the host
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// outputs straight from their registers
	assign reg_rdata     = rdata_r;
	assign low_threshold = low_r;
	assign wide_format   = wide_r;
	assign alert_out     = alert_r;
endmodule : tsc_regs

// >>> verification/tsc_conv_model.sv
// conversion engine model answering start pulses with a result
module tsc_conv_model #(
	parameter int DLY = 3
) (
	input  wire logic        clk,
	input  wire logic        conv_start,
	input  wire logic [15:0] temp_in,
	output logic             conv_done = 1'b0,
	output logic [15:0]      temp_result = 16'h0000,
	output int               starts = 0
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	// result valid only with done, otherwise a changing pattern
	always @(posedge clk) begin
		conv_done <= 1'b0;
		temp_result <= ~temp_result;
		if (conv_start) begin
			starts <= starts + 1;
			cnt <= DLY;
		end else if (cnt == 1) begin
			conv_done <= 1'b1;
			temp_result <= temp_in;
			cnt <= 0;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule : tsc_conv_model

// >>> verification/tsc_regs_monitor.sv
// assertion checker for the configuration and low threshold bank
module tsc_regs_monitor (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        conv_start,
	input wire logic        conv_done,
	input wire logic [15:0] low_threshold,
	input wire logic        wide_format,
	input wire logic        alert_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sd_r;
	// shadow of the shutdown bit
	always_ff @(posedge clk) begin
		if (rst)
			sd_r <= 1'b0;
		else if (reg_wr && reg_addr == 8'h01)
			sd_r <= reg_wdata[8];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	start_gate_a: assert property (conv_start && sd_r |-> reg_wr && reg_addr == 8'h01 && reg_wdata[15])
		else $error("start without trigger in shutdown");
	busy_read_a: assert property (conv_start ##1 (reg_addr == 8'h01 && !conv_done) |=> !reg_rdata[15])
		else $error("trigger not zero while busy");
	low_mask_a: assert property (reg_wr && reg_addr == 8'h02 |=> low_threshold == ($past(reg_wdata) & ($past(wide_format) ? 16'hFFF8 : 16'hFFF0)))
		else $error("low threshold layout wrong");
	low_hold_a: assert property (!(reg_wr && reg_addr == 8'h02) |=> $stable(low_threshold))
		else $error("low threshold changed unwritten");
	wide_wr_a: assert property (reg_wr && reg_addr == 8'h01 |=> wide_format == $past(reg_wdata[4]))
		else $error("wide bit not written");
	low_read_a: assert property (reg_addr == 8'h02 |=>
		reg_rdata == ($past(low_threshold) & ($past(wide_format) ? 16'hFFF8 : 16'hFFF0)))
		else $error("low threshold readback wrong");
	cfg_rsvd_a: assert property (reg_addr == 8'h01 |=> reg_rdata[14:13] == 2'h3 && reg_rdata[3:0] == 4'h0)
		else $error("reserved config bits wrong");
	alert_hold_a: assert property ((!conv_done && !reg_wr && !reg_rd) [*3] |=> $stable(alert_out))
		else $error("alert moved without cause");
	cover property (conv_start);
	cover property ($fell(alert_out));
	cover property (reg_wr && reg_addr == 8'h02);
endmodule : tsc_regs_monitor
bind tsc_regs tsc_regs_monitor i_mon (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start),
	.conv_done(conv_done), .low_threshold(low_threshold), .wide_format(wide_format),
	.alert_out(alert_out));

// >>> verification/tb_tsc_regs.sv
// self-checking bench for the configuration and low threshold bank
module tb_tsc_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, look = 0, p_r = 0;
	logic [7:0]  reg_addr = 8'h01;
	logic [15:0] reg_wdata = 16'h0000, high = 16'h5000, temp = 16'h0000, cfg, w;
	logic [15:0] reg_rdata, low_threshold, temp_result, exp_q[$];
	logic        conv_start, conv_done, wide_format, alert_out;
	int          num_errors = 0, samples_checked = 0, seed = 55, starts, n, s0, nf;
	initial forever #25 clk = ~clk;
	tsc_regs i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start),
		.conv_done(conv_done), .temp_result(temp_result), .high_threshold(high),
		.low_threshold(low_threshold), .wide_format(wide_format), .alert_out(alert_out));
	tsc_conv_model i_conv (.clk(clk), .conv_start(conv_start), .temp_in(temp),
		.conv_done(conv_done), .temp_result(temp_result), .starts(starts));
	// ----
	// tasks
	// ----
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// single-bit pin levels
	task automatic cmp_pin(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_pin
	task automatic conclude;
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clk);
		reg_wr = 0;
	endtask : wr
	// note the expected word, the watcher compares it
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1;
		look = 1;
		exp_q.push_back(e);
		@(negedge clk);
		reg_rd = 0;
		look = 0;
	endtask : rd
	// one triggered conversion with a bounded wait
	task automatic cv(input logic [15:0] t);
		temp = t;
		wr(8'h01, cfg | 16'h8000);
		for (n = 0; n < 20 && conv_done !== 1'b1; n++) @(negedge clk);
		if (n == 20) begin
			num_errors++;
			conclude();
		end
		repeat (3) @(negedge clk);
	endtask : cv
	function automatic logic [15:0] ex(input logic tr, input logic act);
		return {tr, 2'h3, cfg[12:6], ~(act ^ cfg[10]), cfg[4], 4'h0};
	endfunction : ex
	// watcher takes the oldest note when read data settles
	always @(posedge clk) p_r <= look;
	always @(negedge clk) if (p_r) cmp(reg_rdata, exp_q.pop_front());
	// ----
	// sequence
	// ----
	initial begin
		repeat (20) @(negedge clk);
		rst = 0;
		cfg = 16'h0080;
		rd(8'h01, ex(0, 0));
		rd(8'h02, 16'h4B00);
		cmp_pin(alert_out, 1'b1);
		$display("reset values done");
		for (int k = 0; k < 4; k++) begin
			w = $random(seed);
			cfg = k[0] ? 16'h0090 : 16'h0080;
			wr(8'h01, cfg);
			wr(8'h02, w);
			wr(8'h03, ~w);
			cmp_pin(wide_format, k[0]);
			rd(8'h02, w & (k[0] ? 16'hFFF8 : 16'hFFF0));
		end
		wr(8'h01, 16'h0080);
		rd(8'h02, w & 16'hFFF0);
		cmp(low_threshold, w & 16'hFFF8);
		wr(8'h02, 16'h4B00);
		$display("threshold layouts done");
		for (int f = 0; f < 4; f++) begin
			cfg = {3'h0, f[1:0], f[0], 2'h1, 8'h80};
			nf = (f == 0) ? 1 : 2 * f;
			wr(8'h01, cfg);
			repeat (2) @(negedge clk);
			cmp_pin(alert_out, !f[0]);
			repeat (nf - 1) cv(16'h6000);
			cmp_pin(alert_out, !f[0]);
			cv(16'h6000);
			cmp_pin(alert_out, f[0]);
			rd(8'h01, ex(1, 1));
			repeat (nf) cv(16'h1000);
			cmp_pin(alert_out, !f[0]);
		end
		$display("fault counts done");
		s0 = starts;
		cfg = 16'h0080;
		wr(8'h01, cfg);
		wr(8'h01, cfg | 16'h8000);
		repeat (5) @(negedge clk);
		cmp(16'(starts - s0), 0);
		rd(8'h01, ex(0, 0));
		$display("continuous mode done");
		cfg = 16'h0300;
		wr(8'h01, cfg);
		cv(16'h6000);
		cmp_pin(alert_out, 1'b0);
		rd(8'h01, ex(1, 1));
		repeat (2) @(negedge clk);
		cmp_pin(alert_out, 1'b1);
		$display("interrupt mode done");
		conclude();
	end
endmodule : tb_tsc_regs
